// ### rtl/relay_driver_spi_register_bank.sv
// relay_driver_spi_register_bank: SPI slave and register bank of an
// eight-channel relay driver. Shift logic runs on sclk_i; the bank runs
// on clk_sys_i. Assumes chip select stays high at least 6 clk_sys_i
// cycles between frames and sclk_i idles low outside frames.
// Summary of operation
// - frame holds direction, primary, secondary, data
// - switch register bit 1 turns channel on
// - input-0 routing, channel 2 resets set
// - input-1 routing, channel 3 resets set
// - status register read-only, fault bit shown
// - probe register enables open-load current
// - write frame 10, answered with diagnosis
// - read frame 01..10, next reply echoes register
// - fault unless 16, 24, 32 clocks
// - unmapped read returns diagnosis word
`timescale 1ns/100ps
`default_nettype none
`include "relay_bank_map.svh"

module relay_driver_spi_register_bank
    import relay_bank_pkg::*;
(
    // system
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    // spi link
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            miso_oe_n_o,
    // device pins and diagnosis sources
    input  wire logic [1:0] in_pin_i,
    input  wire diag_in_t   diag_i,
    // controls to the power stages
    output logic [7:0]      channel_drive_o,
    output logic [7:0]      openload_probe_o
);

    // link clock domain: shift in on rising edge, count clocks
    logic [15:0] rx_shift_q;
    logic [5:0]  rx_cnt_q;
    logic        fresh_q;

    always_ff @(posedge sclk_i) begin
        rx_shift_q <= {rx_shift_q[14:0], mosi_i};
    end

    // armed by a rising chip select, cleared by the first clock of a frame
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // the count restarts at the first clock, not at cs rise, so it still
    // holds the finished frame's length when the system side judges it
    always_ff @(posedge sclk_i) begin
        if (fresh_q) begin
            rx_cnt_q <= 6'h01;
        end else if (rx_cnt_q != `FRAME_CNT_MAX) begin
            rx_cnt_q <= rx_cnt_q + 6'h01;
        end
    end

    // reply is frozen in the system domain for the whole frame
    logic [15:0] reply_q;
    logic        tx_in_word;
    logic [3:0]  tx_bit;
    assign tx_in_word  = fresh_q | (rx_cnt_q < `FRAME_BITS_BASE);
    assign tx_bit      = fresh_q ? 4'hf : ~rx_cnt_q[3:0];
    assign miso_o      = tx_in_word ? reply_q[tx_bit] : 1'b0;
    assign miso_oe_n_o = cs_n_i;

    // system domain: chip select and input pins through two flops
    logic [2:0] cs_q;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic       frame_end;
    logic       link_idle;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cs_q     <= 3'h7;
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end else begin
            cs_q     <= {cs_q[1:0], cs_n_i};
            pin_s1_q <= in_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign frame_end = cs_q[1] & ~cs_q[2];
    assign link_idle = cs_q[1] & cs_q[2];

    // decode of the frame; shift word and count are static after cs rises
    frame_t frame;
    logic   cnt_ok;
    logic   is_write;
    logic   is_read;
    logic   hit_switch;
    logic   hit_route0;
    logic   hit_route1;
    logic   hit_status;
    logic   hit_probe;
    logic   hit_any;

    assign frame    = frame_t'(rx_shift_q);
    assign cnt_ok   = (rx_cnt_q == `FRAME_BITS_BASE)
                    | (rx_cnt_q == `FRAME_BITS_BASE + `FRAME_BITS_STEP)
                    | (rx_cnt_q == `FRAME_BITS_BASE
                                   + `FRAME_BITS_STEP + `FRAME_BITS_STEP);
    assign is_write = frame_end & cnt_ok
                    & (frame.dir == `DIR_WRITE);
    assign is_read  = frame_end & cnt_ok & (frame.dir == `DIR_READ)
                    & (frame.data[1:0] == `READ_TAIL);

    assign hit_switch = (frame.primary_select == `PRI_SWITCH)
                      & (frame.secondary_select == `SEC_SWITCH);
    assign hit_route0 = (frame.primary_select == `PRI_ROUTE)
                      & (frame.secondary_select == `SEC_ROUTE0);
    assign hit_route1 = (frame.primary_select == `PRI_ROUTE)
                      & (frame.secondary_select == `SEC_ROUTE1);
    assign hit_status = (frame.primary_select == `PRI_ROUTE)
                      & (frame.secondary_select == `SEC_STATUS);
    assign hit_probe  = (frame.primary_select == `PRI_PROBE)
                      & (frame.secondary_select == `SEC_PROBE);
    assign hit_any    = hit_switch | hit_route0 | hit_route1
                      | hit_status | hit_probe;

    // register bank
    logic [7:0] switch_q;
    logic [7:0] route0_q;
    logic [7:0] route1_q;
    logic [7:0] probe_q;
    logic       fault_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            switch_q <= `RST_SWITCH;
            route0_q <= `RST_ROUTE0;
            route1_q <= `RST_ROUTE1;
            probe_q  <= `RST_PROBE;
        end else if (is_write) begin
            if (hit_switch) begin
                switch_q <= frame.data;
            end
            if (hit_route0) begin
                route0_q <= frame.data;
            end
            if (hit_route1) begin
                route1_q <= frame.data;
            end
            if (hit_probe) begin
                probe_q <= frame.data;
            end
        end
    end

    // fault flag starts set and follows each finished frame
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fault_q <= 1'b1;
        end else if (frame_end) begin
            fault_q <= ~cnt_ok;
        end
    end

    logic [7:0] status_word;
    always_comb begin
        status_word = 8'h00;
        status_word[`STATUS_FAULT_BIT] = fault_q;
        status_word[1:0] = pin_s2_q;
    end

    // reply selection for the next frame
    reply_sel_t rsel_q;
    logic [3:0] rpri_q;
    logic [1:0] rsec_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rsel_q <= REPLY_REG;
            rpri_q <= `PRI_ROUTE;
            rsec_q <= `SEC_STATUS;
        end else if (frame_end) begin
            rsel_q <= (is_read & hit_any) ? REPLY_REG
                                          : REPLY_DIAG;
            rpri_q <= frame.primary_select;
            rsec_q <= frame.secondary_select;
        end
    end

    logic [7:0]  reg_data;
    logic [15:0] diag_word;
    logic [15:0] reply_d;

    assign reg_data =
        (rpri_q == `PRI_SWITCH && rsec_q == `SEC_SWITCH) ? switch_q :
        (rpri_q == `PRI_ROUTE && rsec_q == `SEC_ROUTE0)  ? route0_q :
        (rpri_q == `PRI_ROUTE && rsec_q == `SEC_ROUTE1)  ? route1_q :
        (rpri_q == `PRI_ROUTE && rsec_q == `SEC_STATUS)  ? status_word :
        probe_q;
    assign diag_word = {1'b0, diag_i.uv_supply, diag_i.low_vdd,
                        diag_i.mode, fault_q, 1'b0,
                        diag_i.openload_off, diag_i.overload};
    assign reply_d   = (rsel_q == REPLY_REG)
                     ? {`REPLY_HEAD, rpri_q, rsec_q, reg_data}
                     : diag_word;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reply_q <= 16'h0000;
        end else if (link_idle) begin
            reply_q <= reply_d;
        end
    end

    // outputs to the power stages, a channel follows switch or routed pin
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            channel_drive_o  <= 8'h00;
            openload_probe_o <= 8'h00;
        end else begin
            channel_drive_o  <= switch_q
                              | (route0_q & {8{pin_s2_q[0]}})
                              | (route1_q & {8{pin_s2_q[1]}});
            openload_probe_o <= probe_q;
        end
    end

    // checks
    AST_CNT_FIRST: assert property (
        @(posedge sclk_i) disable iff (cs_n_i)
        fresh_q |=> rx_cnt_q == 6'h01)
        else $error("bit count did not restart");

    AST_CNT_STEP: assert property (
        @(posedge sclk_i) disable iff (cs_n_i)
        !fresh_q && rx_cnt_q != `FRAME_CNT_MAX
        |=> rx_cnt_q == $past(rx_cnt_q) + 6'h01)
        else $error("bit count did not advance");

    AST_FAULT_RESET: assert property (
        @(posedge clk_sys_i) srst_i |=> fault_q)
        else $error("fault flag not set after reset");

    AST_FAULT_FRAME: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        frame_end |=> fault_q == !$past(cnt_ok))
        else $error("fault flag wrong after frame");

    AST_RESET_VALUES: assert property (
        @(posedge clk_sys_i)
        srst_i |=> switch_q == 8'h00 && route0_q == 8'h04
                   && route1_q == 8'h08 && probe_q == 8'h00)
        else $error("register reset value wrong");

    AST_WR_SWITCH: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        is_write && hit_switch
        |=> switch_q == $past(frame.data) ##1 channel_drive_o[7:0] != 8'h00
            || switch_q == 8'h00)
        else $error("switch write lost");

    AST_WR_ROUTE: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        is_write && (hit_route0 || hit_route1)
        |=> (route0_q == $past(frame.data)) == $past(hit_route0)
            || route0_q == $past(route0_q))
        else $error("routing write misdirected");

    AST_WR_PROBE: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        is_write && hit_probe
        |=> ##1 openload_probe_o == $past(frame.data, 2))
        else $error("probe write not driven");

    AST_STATUS_RO: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        is_write && hit_status
        |=> $stable(switch_q) && $stable(route0_q)
            && $stable(route1_q) && $stable(probe_q))
        else $error("status write changed a register");

    AST_READ_ECHO: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        is_read && hit_any
        |=> ##1 !link_idle
            || reply_q[15:8] == {2'h2, $past(frame.primary_select, 2),
                                 $past(frame.secondary_select, 2)})
        else $error("read reply header wrong");

    AST_UNMAPPED: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        frame_end && !(is_read && hit_any)
        |=> ##1 !link_idle || (!reply_q[15] && !reply_q[9]))
        else $error("reply not the diagnosis word");

endmodule : relay_driver_spi_register_bank
`default_nettype wire

// ### pkg/relay_bank_map.svh
// relay_bank_map.svh: addresses, reset values and frame counts of the
// relay driver register bank. Included by the design.
`ifndef RELAY_BANK_MAP_SVH
`define RELAY_BANK_MAP_SVH
`define DIR_WRITE        2'h2
`define DIR_READ         2'h1
`define READ_TAIL        2'h2
`define REPLY_HEAD       2'h2
`define PRI_SWITCH       4'h0
`define PRI_ROUTE        4'h1
`define PRI_PROBE        4'h2
`define SEC_SWITCH       2'h0
`define SEC_ROUTE0       2'h0
`define SEC_ROUTE1       2'h1
`define SEC_STATUS       2'h2
`define SEC_PROBE        2'h0
`define RST_SWITCH       8'h00
`define RST_ROUTE0       8'h04
`define RST_ROUTE1       8'h08
`define RST_PROBE        8'h00
`define FRAME_BITS_BASE  6'h10
`define FRAME_BITS_STEP  6'h08
`define FRAME_CNT_MAX    6'h3f
`define STATUS_FAULT_BIT 7
`endif

// ### pkg/relay_bank_pkg.sv
// relay_bank_pkg: frame and diagnosis word layouts, reply selection.
// Assumes relay_bank_map.svh on the include path.
package relay_bank_pkg;
    typedef struct packed {
        logic [1:0] dir;
        logic [3:0] primary_select;
        logic [1:0] secondary_select;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic       uv_supply;
        logic       low_vdd;
        logic [1:0] mode;
        logic       openload_off;
        logic [7:0] overload;
    } diag_in_t;

    typedef enum logic {
        REPLY_DIAG,
        REPLY_REG
    } reply_sel_t;
endpackage : relay_bank_pkg

// ### tb/spi_host_model.sv
// spi_host_model: spi master that sends one frame of n bits, msb first.
// Assumes the bank samples mosi on sclk rise and shows miso while sclk low.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
    // link
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // one rising chip select before the first frame arms the link side
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
        #5;
        cs_n_o = 1'b1;
    end

    // sclk only runs inside frames; mosi is scrambled while released
    task automatic xfer(input logic [31:0] w, input int n,
                        output logic [15:0] got);
        got    = 16'h0;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = w[i];
            #40;
            if (n - 1 - i < 16) got = {got[14:0], miso_i};
            sclk_o = 1'b1;
            #40;
            sclk_o = 1'b0;
        end
        if (n < 16) got = got << (16 - n);
        #40;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// ### tb/tb_relay_driver_spi_register_bank.sv
// tb_relay_driver_spi_register_bank: frames against a behavioural bank.
// Assumes the design package and map header are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_relay_driver_spi_register_bank
    import relay_bank_pkg::*;
;
    logic       clk_sys_i = 1'b0;
    logic       srst_i    = 1'b1;
    logic [1:0] pins      = 2'h0;
    diag_in_t   dg        = '0;
    wire        sclk, cs_n, mosi, miso, oe_n;
    wire        miso_line;
    wire  [7:0] drv, prb;
    logic [7:0] sw, r0, r1, pr;
    logic       flt;
    logic [15:0] exp_reply;
    int         err_count = 0;
    int         n_tests   = 0;
    int         cyc       = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    relay_driver_spi_register_bank u_relay_driver_spi_register_bank (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_n_o(oe_n), .in_pin_i(pins), .diag_i(dg),
        .channel_drive_o(drv), .openload_probe_o(prb));

    // a released line shows the inverse, so a missing enable is caught
    assign miso_line = oe_n ? ~miso : miso;

    spi_host_model u_spi_host_model (
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_line));

    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            err_count++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask : chk16

    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (e !== g) begin
            err_count++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask : chk8

    function automatic logic [15:0] diag_word();
        return {1'b0, dg.uv_supply, dg.low_vdd, dg.mode, flt, 1'b0,
                dg.openload_off, dg.overload};
    endfunction : diag_word

    task automatic run(input logic [31:0] w, input int n);
        logic [15:0] got, f, m;
        logic [7:0]  v;
        logic        hit;
        u_spi_host_model.xfer(w, n, got);
        m = 16'hffff << (16 - ((n < 16) ? n : 16));
        chk16("reply", exp_reply & m, got & m);
        f   = w[15:0];
        flt = !(n == 16 || n == 24 || n == 32);
        if (!flt && f[15:14] == 2'h2) begin
            case (f[13:8])
                6'h00: sw = f[7:0];
                6'h04: r0 = f[7:0];
                6'h05: r1 = f[7:0];
                6'h08: pr = f[7:0];
                default: ;
            endcase
        end
        hit = 1'b1;
        case (f[13:8])
            6'h00: v = sw;
            6'h04: v = r0;
            6'h05: v = r1;
            6'h06: v = {flt, 5'h00, pins};
            6'h08: v = pr;
            default: hit = 1'b0;
        endcase
        if (!flt && hit && f[15:14] == 2'h1 && f[1:0] == 2'h2)
            exp_reply = {2'h2, f[13:8], v};
        else exp_reply = diag_word();
        repeat (12) @(posedge clk_sys_i);
        #1;
        chk8("drive", sw | (r0 & {8{pins[0]}}) | (r1 & {8{pins[1]}}),
             drv);
        chk8("probe", pr, prb);
        @(posedge clk_sys_i) #1;
        pins = 2'($urandom);
        dg   = 13'($urandom);
        exp_reply = (exp_reply[15:14] == 2'h2) ? exp_reply : diag_word();
        $display("frame %h bits %0d done", w, n);
    endtask : run

    // reset for 4 cycles; the model takes the reset values and the first
    // reply after reset is the status register with the fault bit set
    task automatic apply_reset;
        srst_i = 1'b1;
        sw     = 8'h00;
        r0     = 8'h04;
        r1     = 8'h08;
        pr     = 8'h00;
        flt    = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        srst_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        exp_reply = {2'h2, 6'h06, 1'b1, 5'h00, pins};
    endtask : apply_reset

    initial begin
        void'($urandom(61841));
        apply_reset();
        run(32'h4402, 16);
        run(32'h4502, 16);
        run(32'h4602, 16);
        run(32'h4802, 16);
        run(32'h4002, 16);
        for (int k = 0; k < 4; k++) begin
            run({16'h80, 8'($urandom)}, 16);
            run({16'h84, 8'($urandom)}, 16);
            run({16'h85, 8'($urandom)}, 16);
            run({16'h88, 8'($urandom)}, 16);
            run(32'h4402, 16);
        end
        apply_reset();
        run(32'h4402, 16);
        run(32'h86ff, 16);
        run(32'h4602, 16);
        run(32'h4f02, 16);
        run(32'h4400, 16);
        run({16'h80, 8'($urandom)}, 15);
        run({16'h80, 8'($urandom)}, 17);
        run(32'h4002, 16);
        run({8'h5a, 16'h84c3}, 24);
        run({16'h8855, 16'h4802}, 32);
        run(32'h4002, 16);
        stop_test();
    end
endmodule : tb_relay_driver_spi_register_bank

`default_nettype wire
